// ==== hdl/smc_map.svh ====
// register offsets, field positions, reset values and decode constants of the memory controller
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// register byte offsets
`define SMC_OFF_REMAP      8'h00
`define SMC_OFF_ABT_STAT   8'h04
`define SMC_OFF_ABT_ADDR   8'h08

// field positions of the abort status and remap registers
`define SMC_ASR_UNDEF      0
`define SMC_ASR_MISAL      1
`define SMC_ASR_SIZE_LO    8
`define SMC_ASR_TYPE_LO    10
`define SMC_ASR_LAST_LO    16
`define SMC_ASR_SAVED_LO   24
`define SMC_RCR_TOGGLE     0

// reset values
`define SMC_RST_ASR        32'h0000_0000
`define SMC_RST_AASR       32'h0000_0000

// top-level regions, by the four highest address bits
`define SMC_TOP_INTMEM     4'h0
`define SMC_TOP_PERIPH     4'hF

// 1-Mbyte internal areas, by the eight bits below the top nibble
`define SMC_AREA_BOOT      8'h00
`define SMC_AREA_FLASH     8'h01
`define SMC_AREA_SRAM      8'h02
`define SMC_AREA_ROM       8'h03

// address width of each embedded memory, sets the alias period
`define SMC_FLASH_AW       18
`define SMC_SRAM_AW        16
`define SMC_ROM_AW         16

// access size and type codes
`define SMC_SZ_BYTE        2'h0
`define SMC_SZ_HALF        2'h1
`define SMC_SZ_WORD        2'h2
`define SMC_TY_READ        2'h0
`define SMC_TY_WRITE       2'h1
`define SMC_TY_FETCH       2'h2

// master indices: highest priority first
`define SMC_M_ETH          0
`define SMC_M_DMA          1
`define SMC_M_CPU          2

`endif

// ==== hdl/smc_pkg.sv ====
// types shared by the memory controller
package smc_pkg;
	typedef enum logic [1:0] {
		SMC_IDLE   = 2'b00,
		SMC_DECODE = 2'b01,
		SMC_ACCESS = 2'b10
	} smc_state_e;

	typedef logic [2:0]  smc_mst_t;   // one bit per master
	typedef logic [3:0]  smc_tgt_t;   // flash, sram, rom, peripheral
	typedef logic [1:0]  smc_code_t;  // size or type code
endpackage : smc_pkg

// ==== hdl/smc_mem_ctrl.sv ====
// memory controller: arbiter, address decoder, misalignment detector, abort status, wishbone registers
//
// Overview of operation
// - fixed priority grant to one master: ethernet over dma over cpu
// - top four address bits select internal memory, peripherals or undefined space
// - accesses to the fourteen undefined top regions abort
// - eight further bits pick a 1-Mbyte internal area per memory
// - small memories repeat across their area by dropping upper bits
// - unassigned internal areas abort
// - area zero shows flash after reset, sram once remapped
// - aliased memory stays reachable at its own base and at zero
// - each written one toggles the area zero mapping
// - abort goes to all masters at once
// - full 32-bit aborted address is captured
// - size and type of the aborted access are captured
// - separate flags for undefined and misaligned cause
// - exactly one last-source bit set per abort
// - saved-source bits keep earlier aborts not shown by last-source
// - data aborts store the data address
// - misaligned word or half-word accesses are cancelled and aborted
// - alignment checked for all masters except cpu instruction fetches
// - little-endian ordering only
// - reading abort status clears saved-source bits
// - writing zero to the remap bit changes nothing
`timescale 1ns/1ns
`include "smc_map.svh"

module smc_mem_ctrl (
	input  wire logic                clk_i,       // system clock, 20 MHz
	input  wire logic                rst_i,       // synchronous reset, active high
	// masters: bit 0 ethernet, bit 1 dma, bit 2 cpu
	input  wire smc_pkg::smc_mst_t   mst_req_i,   // request per master
	input  wire logic [2:0][31:0]    mst_addr_i,  // address per master
	input  wire logic [2:0][1:0]     mst_size_i,  // size code per master
	input  wire logic [2:0][1:0]     mst_type_i,  // type code per master
	output logic       [2:0]         grant_o,     // one-hot grant
	output logic                     done_o,      // transfer end pulse
	output logic                     abort_o,     // abort pulse to all masters
	// embedded memories and peripheral bridge
	output logic       [3:0]         mem_sel_o,   // target select, one-hot
	output logic       [31:0]        mem_addr_o,  // aliased address
	output logic       [1:0]         mem_size_o,  // access size
	output logic       [1:0]         mem_type_o,  // access type
	output logic                     mem_req_o,   // access request level
	input  wire logic                mem_ack_i,   // access complete
	output logic                     remap_o,     // area zero shows sram
	// wishbone register slave
	input  wire logic                wb_cyc_i,    // cycle
	input  wire logic                wb_stb_i,    // strobe
	input  wire logic                wb_we_i,     // write enable
	input  wire logic [7:0]          wb_adr_i,    // byte address
	input  wire logic [3:0]          wb_sel_i,    // byte lanes
	input  wire logic [31:0]         wb_dat_i,    // write data
	output logic       [31:0]        wb_dat_o,    // read data
	output logic                     wb_ack_o     // acknowledge
);
	import smc_pkg::*;

	// ************************************************************
	// decode functions
	// ************************************************************

	// target select for an address, zero where undefined
	function automatic smc_tgt_t tgt_sel(input logic [31:0] a, input logic remap);
		smc_tgt_t t;
		t = 4'h0;
		if (a[31:28] == `SMC_TOP_PERIPH) begin
			t = 4'h8;
		end else if (a[31:28] == `SMC_TOP_INTMEM) begin
			case (a[27:20])
				`SMC_AREA_BOOT:  t = remap ? 4'h2 : 4'h1;
				`SMC_AREA_FLASH: t = 4'h1;
				`SMC_AREA_SRAM:  t = 4'h2;
				`SMC_AREA_ROM:   t = 4'h4;
				default:         t = 4'h0;
			endcase
		end
		return t;
	endfunction : tgt_sel

	// misalignment check, cpu fetches exempt
	function automatic logic misal(input logic [31:0] a, input logic [1:0] sz,
		input logic [1:0] ty, input smc_mst_t m);
		logic bad;
		bad = ((sz == `SMC_SZ_WORD) && (a[1:0] != 2'h0)) || ((sz == `SMC_SZ_HALF) && a[0]);
		return bad && !(m[`SMC_M_CPU] && (ty == `SMC_TY_FETCH));
	endfunction : misal

	// ************************************************************
	// arbiter and transfer sequence
	// ************************************************************

	smc_state_e          state_q;
	smc_mst_t            grant_q;
	logic [31:0]         addr_q;
	logic [1:0]          size_q;
	logic [1:0]          type_q;
	logic                done_q;
	logic                abort_q;
	logic                remap_q;
	smc_tgt_t            tgt_d;
	logic                undef_d;
	logic                misal_d;
	smc_mst_t            pick_d;
	logic [1:0]          idx_d;

	// fixed priority pick among requests
	// fixed priority
	always_comb begin
		if (mst_req_i[`SMC_M_ETH]) begin
			pick_d = 3'b001;
			idx_d  = 2'd0;
		end else if (mst_req_i[`SMC_M_DMA]) begin
			pick_d = 3'b010;
			idx_d  = 2'd1;
		end else if (mst_req_i[`SMC_M_CPU]) begin
			pick_d = 3'b100;
			idx_d  = 2'd2;
		end else begin
			pick_d = 3'b000;
			idx_d  = 2'd0;
		end
	end

	// classify the latched access
	always_comb begin
		tgt_d   = tgt_sel(addr_q, remap_q);
		undef_d = (tgt_d == 4'h0);
		misal_d = misal(addr_q, size_q, type_q, grant_q);
	end

	// state, grant and request latch
	// grant held to completion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= SMC_IDLE;
			grant_q <= 3'b000;
			addr_q  <= 32'h0000_0000;
			size_q  <= 2'h0;
			type_q  <= 2'h0;
		end else begin
			case (state_q)
				SMC_IDLE: begin
					if ((pick_d != 3'b000) && !done_q) begin
						grant_q <= pick_d;
						addr_q  <= mst_addr_i[idx_d];
						size_q  <= mst_size_i[idx_d];
						type_q  <= mst_type_i[idx_d];
						state_q <= SMC_DECODE;
					end
				end
				SMC_DECODE: begin
					if (undef_d || misal_d) begin
						grant_q <= 3'b000;
						state_q <= SMC_IDLE;
					end else begin
						state_q <= SMC_ACCESS;
					end
				end
				SMC_ACCESS: begin
					if (mem_ack_i) begin
						grant_q <= 3'b000;
						state_q <= SMC_IDLE;
					end
				end
				default: begin
					grant_q <= 3'b000;
					state_q <= SMC_IDLE;
				end
			endcase
		end
	end

	// end of transfer and abort pulses
	// abort broadcast
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_q  <= 1'b0;
			abort_q <= 1'b0;
		end else begin
			abort_q <= (state_q == SMC_DECODE) && (undef_d || misal_d);
			done_q  <= ((state_q == SMC_DECODE) && (undef_d || misal_d))
				|| ((state_q == SMC_ACCESS) && mem_ack_i);
		end
	end

	// memory side request, aliased address
	// alias by masking
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_req_o  <= 1'b0;
			mem_sel_o  <= 4'h0;
			mem_addr_o <= 32'h0000_0000;
			mem_size_o <= 2'h0;
			mem_type_o <= 2'h0;
		end else if ((state_q == SMC_DECODE) && !undef_d && !misal_d) begin
			mem_req_o  <= 1'b1;
			mem_sel_o  <= tgt_d;
			mem_size_o <= size_q;
			mem_type_o <= type_q;
			case (tgt_d)
				4'h1:    mem_addr_o <= {{(32 - `SMC_FLASH_AW){1'b0}}, addr_q[`SMC_FLASH_AW-1:0]};
				4'h2:    mem_addr_o <= {{(32 - `SMC_SRAM_AW){1'b0}}, addr_q[`SMC_SRAM_AW-1:0]};
				4'h4:    mem_addr_o <= {{(32 - `SMC_ROM_AW){1'b0}}, addr_q[`SMC_ROM_AW-1:0]};
				default: mem_addr_o <= addr_q;
			endcase
		end else if ((state_q == SMC_ACCESS) && mem_ack_i) begin
			mem_req_o <= 1'b0;
			mem_sel_o <= 4'h0;
		end
	end

	// ************************************************************
	// wishbone slave and registers
	// ************************************************************

	logic                ack_q;
	logic                wr_hit;
	logic                rd_asr;
	logic                abt_ev;
	logic                fresh_q;
	logic                undef_q;
	logic                misal_q;
	logic [1:0]          asz_q;
	logic [1:0]          aty_q;
	smc_mst_t            last_q;
	smc_mst_t            saved_q;
	logic [31:0]         aadr_q;

	// access strobes taken at the acknowledge edge
	always_comb begin
		wr_hit = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0]
			&& (wb_adr_i == `SMC_OFF_REMAP);
		rd_asr = wb_cyc_i && wb_stb_i && ack_q && !wb_we_i && (wb_adr_i == `SMC_OFF_ABT_STAT);
		abt_ev = (state_q == SMC_DECODE) && (undef_d || misal_d);
	end

	// single-wait acknowledge, dropped after one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
		end
	end

	// read data mux, unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
			case (wb_adr_i)
				`SMC_OFF_ABT_STAT: begin
					wb_dat_o <= 32'h0000_0000;
					wb_dat_o[`SMC_ASR_UNDEF]                      <= undef_q;
					wb_dat_o[`SMC_ASR_MISAL]                      <= misal_q;
					wb_dat_o[`SMC_ASR_SIZE_LO +: 2]               <= asz_q;
					wb_dat_o[`SMC_ASR_TYPE_LO +: 2]               <= aty_q;
					wb_dat_o[`SMC_ASR_LAST_LO +: 3]               <= last_q;
					wb_dat_o[`SMC_ASR_SAVED_LO +: 3]              <= saved_q;
				end
				`SMC_OFF_ABT_ADDR: wb_dat_o <= aadr_q;
				default:           wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// remap toggle
	// flash at reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remap_q <= 1'b0;
		end else if (wr_hit && wb_dat_i[`SMC_RCR_TOGGLE]) begin
			remap_q <= !remap_q;
		end
	end

	// captured abort fields
	// full address
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aadr_q  <= `SMC_RST_AASR;
			undef_q <= 1'b0;
			misal_q <= 1'b0;
			asz_q   <= 2'h0;
			aty_q   <= 2'h0;
			last_q  <= 3'b000;
		end else if (abt_ev) begin
			aadr_q  <= addr_q;
			undef_q <= undef_d;
			misal_q <= misal_d;
			asz_q   <= size_q;
			aty_q   <= type_q;
			last_q  <= grant_q;
		end
	end

	// saved sources: previous shown abort moves here unless status was read since; the read clear beats a new abort
	// earlier aborts saved
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			saved_q <= 3'b000;
			fresh_q <= 1'b0;
		end else begin
			saved_q <= (rd_asr ? 3'b000 : saved_q) | ((abt_ev && fresh_q && !rd_asr) ? last_q : 3'b000);
			fresh_q <= abt_ev || (fresh_q && !rd_asr);
		end
	end

	// registered outputs
	always_comb begin
		grant_o  = grant_q;
		done_o   = done_q;
		abort_o  = abort_q;
		remap_o  = remap_q;
		wb_ack_o = ack_q;
	end

	// ************************************************************
	// checks
	// ************************************************************

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_grant_onehot: assert property ($onehot0(grant_q))
		else $error("grant not one-hot");
	chk_grant_prio: assert property ((state_q == SMC_IDLE) && !done_q && mst_req_i[0] |=> grant_q == 3'b001)
		else $error("ethernet lost arbitration");
	chk_undef_abort: assert property ((state_q == SMC_DECODE) && (addr_q[31:28] inside {[4'h1:4'hE]})
		|=> abort_q && undef_q)
		else $error("undefined region not aborted");
	chk_area_abort: assert property ((state_q == SMC_DECODE) && (addr_q[31:20] > 12'h003)
		&& (addr_q[31:28] == 4'h0) |=> abort_q)
		else $error("unassigned area not aborted");
	chk_boot_map: assert property ((state_q == SMC_DECODE) && !abt_ev && (addr_q[31:20] == 12'h000)
		|=> mem_sel_o == (remap_q ? 4'h2 : 4'h1))
		else $error("area zero mapped wrongly");
	chk_remap_toggle: assert property (wr_hit && wb_dat_i[0] |=> remap_q != $past(remap_q))
		else $error("remap did not toggle");
	chk_remap_zero: assert property (wr_hit && !wb_dat_i[0] |=> $stable(remap_q))
		else $error("zero write changed remap");
	chk_abort_addr: assert property (abt_ev |=> (aadr_q == $past(addr_q)) && (last_q == $past(grant_q)))
		else $error("abort address or source not captured");
	chk_last_one: assert property (abort_q |-> $onehot(last_q) && done_q)
		else $error("last source not one-hot");
	chk_misal_word: assert property ((state_q == SMC_DECODE) && (size_q == 2'h2) && (addr_q[1:0] != 2'h0)
		&& !(grant_q[2] && type_q == 2'h2) |=> abort_q && misal_q && !mem_req_o)
		else $error("misaligned word not aborted");
	chk_fetch_free: assert property ((state_q == SMC_DECODE) && grant_q[2] && (type_q == 2'h2) && !undef_d
		|=> !abort_q)
		else $error("cpu fetch aborted");
	chk_saved_clear: assert property (rd_asr && !abt_ev |=> saved_q == 3'b000)
		else $error("saved sources not cleared");
	chk_hold_fields: assert property (!abt_ev |=> $stable(aadr_q) && $stable(last_q) && $stable(asz_q))
		else $error("abort fields changed");
	chk_grant_hold: assert property ((state_q == SMC_ACCESS) && !mem_ack_i |=> $stable(grant_q))
		else $error("grant changed mid transfer");

	cov_abort: cover property (abort_q);
	cov_remapped_boot: cover property (mem_req_o && remap_q && (mem_sel_o == 4'h2));
	cov_saved: cover property (saved_q != 3'b000);
endmodule : smc_mem_ctrl

// ==== sim/smc_mem_model.sv ====
// embedded memory responder standing behind the memory controller
`timescale 1ns/1ns

module smc_mem_model (
	input  wire logic       clk_i,     // system clock
	input  wire logic       rst_i,     // synchronous reset, active high
	input  wire logic       mem_req_i, // request level from controller
	input  wire logic [3:0] delay_i,   // wait cycles before answering
	output logic            mem_ack_o  // one-cycle completion
);
	logic [3:0] wait_q;
	logic       done_q;

	// one answer per request
	// counting waits lets the bench stall a transfer on purpose
	always_ff @(posedge clk_i) begin
		if (rst_i || !mem_req_i) begin
			wait_q    <= 4'h0;
			done_q    <= 1'b0;
			mem_ack_o <= 1'b0;
		end else if (!done_q && wait_q == delay_i) begin
			mem_ack_o <= 1'b1;
			done_q    <= 1'b1;
		end else begin
			mem_ack_o <= 1'b0;
			wait_q    <= wait_q + 4'h1;
		end
	end
endmodule : smc_mem_model

// ==== sim/tb_top.sv ====
// self-checking bench of the memory controller
`timescale 1ns/1ns
`include "smc_map.svh"

module tb_top;
	logic                clk_i;
	logic                rst_i;
	smc_pkg::smc_mst_t   mst_req_i;
	logic [2:0][31:0]    mst_addr_i;
	logic [2:0][1:0]     mst_size_i;
	logic [2:0][1:0]     mst_type_i;
	logic [2:0]          grant_o;
	logic                done_o;
	logic                abort_o;
	logic [3:0]          mem_sel_o;
	logic [31:0]         mem_addr_o;
	logic [1:0]          mem_size_o;
	logic [1:0]          mem_type_o;
	logic                mem_req_o;
	logic                mem_ack_i;
	logic                remap_o;
	logic                wb_cyc_i;
	logic                wb_stb_i;
	logic                wb_we_i;
	logic [7:0]          wb_adr_i;
	logic [3:0]          wb_sel_i;
	logic [31:0]         wb_dat_i;
	logic [31:0]         wb_dat_o;
	logic                wb_ack_o;
	logic [3:0]          mem_dly;
	logic [31:0]         q;
	int                  fails;
	int                  checks_done;

	smc_mem_ctrl smc_mem_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .mst_req_i(mst_req_i),
		.mst_addr_i(mst_addr_i), .mst_size_i(mst_size_i), .mst_type_i(mst_type_i), .grant_o(grant_o),
		.done_o(done_o), .abort_o(abort_o), .mem_sel_o(mem_sel_o), .mem_addr_o(mem_addr_o),
		.mem_size_o(mem_size_o), .mem_type_o(mem_type_o), .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i),
		.remap_o(remap_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o));

	smc_mem_model smc_mem_model_inst (.clk_i(clk_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
		.delay_i(mem_dly), .mem_ack_o(mem_ack_i));

	// 20 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("fails=%0d checks_done=%0d", fails, checks_done);
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	// one classic wishbone cycle, held until ack is sampled high at a rising edge
	// read data is taken at that same edge, and only then is the request released
	task automatic wb_acc(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		check({31'h0, wb_ack_o}, 32'h1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask : wb_acc

	// one master transfer, judged on grant, abort, target, offset and code
	task automatic mst_acc(input int m, input logic [31:0] a, input logic [1:0] sz, input logic [1:0] ty,
		input logic ab, input logic [3:0] sel, input logic [31:0] ma);
		logic [2:0]  g;
		logic [3:0]  s;
		logic [31:0] x;
		logic [3:0]  st;
		int          n;
		g = 3'h0;
		s = 4'h0;
		x = 32'h0;
		st = 4'h0;
		n = 0;
		@(posedge clk_i);
		mst_req_i[m]  <= 1'b1;
		mst_addr_i[m] <= a;
		mst_size_i[m] <= sz;
		mst_type_i[m] <= ty;
		do begin
			@(negedge clk_i);
			n++;
			if (grant_o != 3'h0)
				g = grant_o;
			if (mem_req_o === 1'b1) begin
				s = mem_sel_o;
				x = mem_addr_o;
				st = {mem_type_o, mem_size_o};
			end
		end while (done_o !== 1'b1 && n < 50);
		check({31'h0, done_o}, 32'h1);
		check({29'h0, g}, 32'h1 << m);
		check({31'h0, abort_o}, {31'h0, ab});
		check({28'h0, s}, {28'h0, sel});
		check(x, ma);
		if (!ab)
			check({28'h0, st}, {28'h0, ty, sz});
		// master ends its access on done or abort
		@(posedge clk_i);
		mst_req_i[m] <= 1'b0;
	endtask : mst_acc

	// ****************************************
	// scenarios
	// ****************************************
	task automatic reset_regs();
		wb_acc(1'b0, `SMC_OFF_ABT_STAT, 32'h0, q);
		check(q, `SMC_RST_ASR);
		wb_acc(1'b0, `SMC_OFF_ABT_ADDR, 32'h0, q);
		check(q, `SMC_RST_AASR);
		wb_acc(1'b1, 8'h40, 32'hFFFF_FFFF, q);
		wb_acc(1'b0, 8'h40, 32'h0, q);
		check(q, 32'h0);
		check({31'h0, remap_o}, 32'h0);
	endtask : reset_regs

	task automatic decode_map();
		mst_acc(0, 32'h0000_0008, `SMC_SZ_WORD, `SMC_TY_READ, 1'b0, 4'h1, 32'h8);
		mst_acc(1, 32'h0014_0004, `SMC_SZ_WORD, `SMC_TY_WRITE, 1'b0, 4'h1, 32'h4);
		mst_acc(2, 32'h0021_2344, `SMC_SZ_WORD, `SMC_TY_FETCH, 1'b0, 4'h2, 32'h2344);
		mst_acc(0, 32'h0030_FFFC, `SMC_SZ_WORD, `SMC_TY_READ, 1'b0, 4'h4, 32'hFFFC);
		mst_acc(1, 32'hF000_0010, `SMC_SZ_WORD, `SMC_TY_READ, 1'b0, 4'h8, 32'hF000_0010);
	endtask : decode_map

	task automatic abort_record();
		mst_acc(1, 32'h1000_0000, `SMC_SZ_WORD, `SMC_TY_READ, 1'b1, 4'h0, 32'h0);
		mst_acc(2, 32'h0040_0002, `SMC_SZ_HALF, `SMC_TY_WRITE, 1'b1, 4'h0, 32'h0);
		wb_acc(1'b0, `SMC_OFF_ABT_ADDR, 32'h0, q);
		check(q, 32'h0040_0002);
		wb_acc(1'b0, `SMC_OFF_ABT_STAT, 32'h0, q);
		check(q, 32'h0204_0501);
		mst_acc(0, 32'h0020_0100, `SMC_SZ_WORD, `SMC_TY_READ, 1'b0, 4'h2, 32'h100);
		wb_acc(1'b0, `SMC_OFF_ABT_STAT, 32'h0, q);
		check(q, 32'h0004_0501);
		wb_acc(1'b0, `SMC_OFF_ABT_ADDR, 32'h0, q);
		check(q, 32'h0040_0002);
	endtask : abort_record

	task automatic misalign();
		mst_acc(0, 32'h0020_0002, `SMC_SZ_WORD, `SMC_TY_READ, 1'b1, 4'h0, 32'h0);
		mst_acc(1, 32'h0020_0001, `SMC_SZ_HALF, `SMC_TY_WRITE, 1'b1, 4'h0, 32'h0);
		mst_acc(2, 32'h0020_0002, `SMC_SZ_WORD, `SMC_TY_FETCH, 1'b0, 4'h2, 32'h2);
		mst_acc(2, 32'h0020_0003, `SMC_SZ_BYTE, `SMC_TY_READ, 1'b0, 4'h2, 32'h3);
		mst_acc(2, 32'h0020_0001, `SMC_SZ_WORD, `SMC_TY_READ, 1'b1, 4'h0, 32'h0);
		wb_acc(1'b0, `SMC_OFF_ABT_ADDR, 32'h0, q);
		check(q, 32'h0020_0001);
		wb_acc(1'b0, `SMC_OFF_ABT_STAT, 32'h0, q);
		check(q, 32'h0304_0202);
	endtask : misalign

	task automatic remap_toggle();
		wb_acc(1'b1, `SMC_OFF_REMAP, 32'h1, q);
		@(negedge clk_i);
		check({31'h0, remap_o}, 32'h1);
		mst_acc(2, 32'h0000_0010, `SMC_SZ_WORD, `SMC_TY_FETCH, 1'b0, 4'h2, 32'h10);
		mst_acc(1, 32'h0020_0010, `SMC_SZ_WORD, `SMC_TY_READ, 1'b0, 4'h2, 32'h10);
		wb_acc(1'b1, `SMC_OFF_REMAP, 32'h0, q);
		@(negedge clk_i);
		check({31'h0, remap_o}, 32'h1);
		wb_acc(1'b1, `SMC_OFF_REMAP, 32'h1, q);
		@(negedge clk_i);
		check({31'h0, remap_o}, 32'h0);
		mst_acc(0, 32'h0000_0010, `SMC_SZ_WORD, `SMC_TY_READ, 1'b0, 4'h1, 32'h10);
	endtask : remap_toggle

	// cpu holds a stalled grant while both others queue up
	task automatic prio_hold();
		logic [2:0] g;
		logic [2:0] exp [3];
		int         k;
		int         n;
		exp = '{3'b100, 3'b001, 3'b010};
		@(posedge clk_i);
		mem_dly          <= 4'h4;
		mst_req_i[2]     <= 1'b1;
		mst_addr_i[2]    <= 32'h0020_0100;
		@(posedge clk_i);
		mst_req_i[1:0]   <= 2'b11;
		mst_addr_i[1]    <= 32'h0020_0200;
		mst_addr_i[0]    <= 32'h0020_0300;
		for (k = 0; k < 3; k++) begin
			n = 0;
			g = 3'h0;
			do begin
				@(negedge clk_i);
				n++;
				if (grant_o != 3'h0)
					g = grant_o;
			end while (done_o !== 1'b1 && n < 50);
			check({31'h0, done_o}, 32'h1);
			check({29'h0, g}, {29'h0, exp[k]});
			@(posedge clk_i);
			mst_req_i <= mst_req_i & ~g;
		end
	endtask : prio_hold

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		fails = 0;
		checks_done = 0;
		rst_i = 1'b1;
		mst_req_i = 3'h0;
		mst_addr_i = '0;
		mst_size_i = {3{`SMC_SZ_WORD}};
		mst_type_i = '0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		mem_dly = 4'h1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		reset_regs();
		decode_map();
		abort_record();
		misalign();
		remap_toggle();
		prio_hold();
		give_verdict();
	end

	initial begin
		#1_000_000;
		fails++;
		give_verdict();
	end
endmodule : tb_top
